// File: hdl/p3_link_regs.svh
// constants for the third-port link block: timing, strap codes, byte framing
// assumes inclusion by p3_link.sv only; holds definitions and nothing else
`ifndef P3_LINK_REGS_SVH
`define P3_LINK_REGS_SVH

// system clock period in ns
`define P3_CLK_NS        40
// nibble link clock periods in ns at 100 and 10 Mb/s
`define P3_NIB100_NS     40
`define P3_NIB10_NS      400
// serial link clock period in ns
`define P3_SERIAL_NS     100

// mode strap codes, sampled once after reset
`define P3_STRAP_FWD     2'h0
`define P3_STRAP_REV     2'h1
// cycles of synchronised strap before capture
`define P3_STRAP_WAIT    2'h3

// last unit index within one byte
`define P3_NIB_LAST      3'h1
`define P3_BIT_LAST      3'h7
// shift step per unit
`define P3_NIB_STEP      4
`define P3_BIT_STEP      1

`endif

// File: hdl/p3_link_pkg.sv
// types shared by the third-port link block
// assumes nothing beyond a SystemVerilog compiler
package p3_link_pkg;

  // link personality fixed at reset
  typedef enum logic [1:0] {MODE_FWD, MODE_REV, MODE_SERIAL} link_mode_t;

endpackage

// File: hdl/p3_fifo.sv
// small valid/ready buffer with honest full and empty
// assumes one clock; drain side may stall for any time
`timescale 1ns/1ps
module p3_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  input  wire logic             i_valid,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_ready,
  output logic                  o_valid,
  output logic      [WIDTH-1:0] o_data,
  input  wire logic             i_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [CW-1:0]    cnt_q;
  logic             push;
  logic             pop;

  // full and empty come straight from the count
  assign o_ready = (cnt_q != CW'(DEPTH));
  assign o_valid = (cnt_q != '0);
  assign o_data  = mem_q[rd_q];
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  // storage, no reset needed on the data
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= i_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= bump(wr_q);
      end
      if (pop)
      begin
        rd_q <= bump(rd_q);
      end
      if (push && !pop)
      begin
        cnt_q <= CW'(cnt_q + 1'b1);
      end
      else if (pop && !push)
      begin
        cnt_q <= CW'(cnt_q - 1'b1);
      end
    end
  end
endmodule

// File: hdl/p3_link.sv
// third-port external link: nibble interface (forward/reverse) or serial link
// assumes a 25 MHz system clock; link clocks and pins are asynchronous to it
//
// Behaviour
// - forward acts as MAC, reverse as PHY
// - nibble link moves four bits per clock
// - enable and valid qualify every nibble
// - no error outputs; error input ignored
// - reverse pins connect by name to MAC
// - forward pins cross over to the PHY
// - serial mode: PHY role, one bit per clock
// - serial pins: data bit 0, carrier on valid
// - serial link clock period 80 ns
// - nibble clock 80 or 400 ns period
// - half duplex collision shown while sending and receiving at once
`timescale 1ns/1ps
`include "p3_link_regs.svh"
module p3_link #(
  parameter int BUF_DEPTH = 2
) (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic [1:0] i_mode_strap,
  input  wire logic       i_speed_100,
  input  wire logic       i_half_duplex,
  input  wire logic       i_port3_tx_enable,
  input  wire logic [3:0] i_port3_tx_nibble,
  input  wire logic       i_port3_tx_error,
  input  wire logic       i_port3_tx_clock,
  output logic            o_port3_tx_clock,
  output logic            o_port3_tx_clock_oe,
  input  wire logic       i_port3_rx_clock,
  output logic            o_port3_rx_clock,
  output logic            o_port3_rx_clock_oe,
  output logic            o_port3_rx_valid,
  output logic [3:0]      o_port3_rx_nibble,
  output logic            o_port3_collision,
  output logic            o_port3_collision_oe,
  input  wire logic       i_port3_collision_in,
  input  wire logic       i_port3_carrier_sense,
  output logic            o_port3_carrier_sense,
  output logic            o_port3_carrier_sense_oe,
  input  wire logic       i_eg_valid,
  input  wire logic [7:0] i_eg_data,
  input  wire logic       i_eg_last,
  output logic            o_eg_ready,
  output logic            o_eg_underrun,
  output logic            o_in_valid,
  output logic [7:0]      o_in_data,
  output logic            o_in_last,
  input  wire logic       i_in_ready,
  output logic            o_in_overrun,
  output logic            o_in_fragment,
  output logic            o_collision,
  output logic            o_carrier_sense,
  output p3_link_pkg::link_mode_t o_mode,
  output logic            o_mode_valid
);
  import p3_link_pkg::*;

  // half period of a generated link clock, in system cycles, never below one
  function automatic logic [7:0] half_cycles(input int period_ns);
    int h;
    h = period_ns / (2 * `P3_CLK_NS);
    if (h < 1)
    begin
      h = 1;
    end
    half_cycles = h[7:0];
  endfunction

  localparam logic [7:0] HALF_NIB100 = half_cycles(`P3_NIB100_NS);
  localparam logic [7:0] HALF_NIB10  = half_cycles(`P3_NIB10_NS);
  localparam logic [7:0] HALF_SERIAL = half_cycles(`P3_SERIAL_NS);

  // every pin input and strap goes through two flops before use
  logic [11:0] meta_q;
  logic [11:0] sync_q;
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      meta_q <= 12'h000;
      sync_q <= 12'h000;
    end
    else
    begin
      meta_q <= {i_mode_strap, i_speed_100, i_port3_tx_clock, i_port3_rx_clock,
                 i_port3_tx_enable, i_port3_tx_nibble, i_port3_collision_in,
                 i_port3_carrier_sense};
      sync_q <= meta_q;
    end
  end

  logic [1:0] strap_s;
  logic       speed_s;
  logic       txc_s;
  logic       rxc_s;
  logic       rxen_s;
  logic [3:0] rxd_s;
  logic       col_s;
  logic       crs_s;
  assign {strap_s, speed_s, txc_s, rxc_s, rxen_s, rxd_s, col_s, crs_s} = sync_q;

  // strap capture once
  // the strap is caught a few cycles after release, then frozen
  link_mode_t mode_q;
  logic       speed_q;
  logic       cfg_ok_q;
  logic [1:0] wait_q;
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      mode_q   <= MODE_FWD;
      speed_q  <= 1'b0;
      cfg_ok_q <= 1'b0;
      wait_q   <= 2'h0;
    end
    else if (!cfg_ok_q)
    begin
      wait_q <= 2'(wait_q + 1'b1);
      if (wait_q == `P3_STRAP_WAIT)
      begin
        cfg_ok_q <= 1'b1;
        speed_q  <= speed_s;
        case (strap_s)
          `P3_STRAP_FWD: mode_q <= MODE_FWD;
          `P3_STRAP_REV: mode_q <= MODE_REV;
          default:       mode_q <= MODE_SERIAL;
        endcase
      end
    end
  end

  logic serial;
  logic gen_mode;
  assign serial   = (mode_q == MODE_SERIAL);
  assign gen_mode = cfg_ok_q & (mode_q != MODE_FWD);
  assign o_mode       = mode_q;
  assign o_mode_valid = cfg_ok_q;

  // generated link clock
  // 100 Mb/s nibble and serial clocks are limited by the 25 MHz divider
  logic [7:0] half;
  logic [7:0] div_q;
  logic       gen_clk_q;
  logic       div_done;
  assign half     = serial ? HALF_SERIAL : (speed_q ? HALF_NIB100 : HALF_NIB10);
  assign div_done = gen_mode & (div_q == 8'(half - 8'h01));
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      div_q     <= 8'h00;
      gen_clk_q <= 1'b0;
    end
    else if (div_done)
    begin
      div_q     <= 8'h00;
      gen_clk_q <= ~gen_clk_q;
    end
    else if (gen_mode)
    begin
      div_q <= 8'(div_q + 8'h01);
    end
  end

  // clock source by role
  // as MAC the PHY's clocks are sampled; as PHY the divider supplies both
  logic txc_p_q;
  logic rxc_p_q;
  logic out_tick;
  logic in_tick;
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      txc_p_q <= 1'b0;
      rxc_p_q <= 1'b0;
    end
    else
    begin
      txc_p_q <= txc_s;
      rxc_p_q <= rxc_s;
    end
  end
  assign out_tick = cfg_ok_q & (gen_mode ? (div_done & gen_clk_q) : (txc_s & ~txc_p_q));
  assign in_tick  = cfg_ok_q & (gen_mode ? (div_done & ~gen_clk_q) : (rxc_s & ~rxc_p_q));

  logic [2:0] unit_last;
  assign unit_last = serial ? `P3_BIT_LAST : `P3_NIB_LAST;

  // egress holding byte, refilled by the core
  logic [7:0] hold_q;
  logic       hold_v_q;
  logic       hold_last_q;
  logic [7:0] sh_q;
  logic [2:0] out_cnt_q;
  logic       act_q;
  logic       last_q;
  logic       take;
  assign o_eg_ready = ~hold_v_q;
  assign take = out_tick & hold_v_q & (~act_q | ((out_cnt_q == unit_last) & ~last_q));
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      hold_q      <= 8'h00;
      hold_v_q    <= 1'b0;
      hold_last_q <= 1'b0;
    end
    else if (i_eg_valid && !hold_v_q)
    begin
      hold_q      <= i_eg_data;
      hold_v_q    <= 1'b1;
      hold_last_q <= i_eg_last;
    end
    else if (take)
    begin
      hold_v_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sh_q          <= 8'h00;
      out_cnt_q     <= 3'h0;
      act_q         <= 1'b0;
      last_q        <= 1'b0;
      o_eg_underrun <= 1'b0;
    end
    else
    begin
      o_eg_underrun <= 1'b0;
      if (take)
      begin
        sh_q      <= hold_q;
        out_cnt_q <= 3'h0;
        act_q     <= 1'b1;
        last_q    <= hold_last_q;
      end
      else if (out_tick && act_q && out_cnt_q != unit_last)
      begin
        sh_q      <= serial ? (sh_q >> `P3_BIT_STEP) : (sh_q >> `P3_NIB_STEP);
        out_cnt_q <= 3'(out_cnt_q + 1'b1);
      end
      else if (out_tick && act_q)
      begin
        // a starved core ends the frame early rather than stretching it
        act_q         <= 1'b0;
        o_eg_underrun <= ~last_q;
      end
    end
  end

  // ingress assembly; one byte held back so the frame end can mark it last
  logic [7:0] asm_q;
  logic [7:0] asm_next;
  logic [7:0] pend_q;
  logic       pend_v_q;
  logic [2:0] in_cnt_q;
  logic       rx_act_q;
  logic       byte_full;
  logic       frame_end;
  logic       push;
  logic       buf_ready;
  assign asm_next  = serial ? {rxd_s[0], asm_q[7:1]} : {rxd_s, asm_q[7:4]};
  assign byte_full = in_tick & rxen_s & (in_cnt_q == unit_last);
  assign frame_end = in_tick & ~rxen_s & rx_act_q;
  assign push      = pend_v_q & (byte_full | frame_end);

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      asm_q         <= 8'h00;
      pend_q        <= 8'h00;
      pend_v_q      <= 1'b0;
      in_cnt_q      <= 3'h0;
      rx_act_q      <= 1'b0;
      o_in_fragment <= 1'b0;
      o_in_overrun  <= 1'b0;
    end
    else
    begin
      o_in_fragment <= frame_end & (in_cnt_q != 3'h0);
      o_in_overrun  <= push & ~buf_ready;
      if (in_tick)
      begin
        rx_act_q <= rxen_s;
      end
      if (in_tick && rxen_s)
      begin
        asm_q    <= asm_next;
        in_cnt_q <= byte_full ? 3'h0 : 3'(in_cnt_q + 1'b1);
      end
      else if (frame_end)
      begin
        in_cnt_q <= 3'h0;
      end
      if (byte_full)
      begin
        pend_q   <= asm_next;
        pend_v_q <= 1'b1;
      end
      else if (frame_end)
      begin
        pend_v_q <= 1'b0;
      end
    end
  end

  // the link cannot pause, so the buffer absorbs a stalled core
  p3_fifo #(
    .WIDTH (9),
    .DEPTH (BUF_DEPTH)
  ) u_in_buf (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_valid  (push),
    .i_data   ({frame_end, pend_q}),
    .o_ready  (buf_ready),
    .o_valid  (o_in_valid),
    .o_data   ({o_in_last, o_in_data}),
    .i_ready  (i_in_ready)
  );

  // error input ignored
  // the tx error pin is deliberately left out of every path
  logic unused_err;
  assign unused_err = i_port3_tx_error;

  // pin drive and collision
  // outputs are registered so pins never glitch on mode logic
  logic col_d;
  logic crs_d;
  assign col_d = gen_mode ? (i_half_duplex & act_q & rx_act_q) : col_s;
  assign crs_d = gen_mode ? (act_q | rx_act_q) : crs_s;
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_port3_rx_valid         <= 1'b0;
      o_port3_rx_nibble        <= 4'h0;
      o_port3_tx_clock         <= 1'b0;
      o_port3_rx_clock         <= 1'b0;
      o_port3_tx_clock_oe      <= 1'b0;
      o_port3_rx_clock_oe      <= 1'b0;
      o_port3_collision        <= 1'b0;
      o_port3_collision_oe     <= 1'b0;
      o_port3_carrier_sense    <= 1'b0;
      o_port3_carrier_sense_oe <= 1'b0;
      o_collision              <= 1'b0;
      o_carrier_sense          <= 1'b0;
    end
    else
    begin
      // serial mode shows carrier on the valid pin
      o_port3_rx_valid         <= serial ? crs_d : act_q;
      o_port3_rx_nibble        <= serial ? {3'h0, sh_q[0]} : sh_q[3:0];
      o_port3_tx_clock         <= gen_clk_q;
      o_port3_rx_clock         <= gen_clk_q;
      o_port3_tx_clock_oe      <= gen_mode;
      o_port3_rx_clock_oe      <= gen_mode;
      o_port3_collision        <= gen_mode & col_d;
      o_port3_collision_oe     <= gen_mode;
      o_port3_carrier_sense    <= gen_mode & crs_d;
      o_port3_carrier_sense_oe <= cfg_ok_q & (mode_q == MODE_REV);
      o_collision              <= col_d;
      o_carrier_sense          <= crs_d;
    end
  end
endmodule

// File: verif/p3_link_sva.sv
// port checker for the third-port link
// assumes a bind from the bench top; one clock domain
`timescale 1ns/1ps
module p3_link_sva
  import p3_link_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_arst_n,
  input wire logic       i_half_duplex,
  input wire logic       i_eg_valid,
  input wire logic       o_eg_ready,
  input wire logic       i_in_ready,
  input wire logic       o_in_valid,
  input wire logic [7:0] o_in_data,
  input wire logic       o_in_last,
  input wire logic       o_port3_tx_clock_oe,
  input wire logic       o_port3_rx_clock_oe,
  input wire logic       o_port3_collision_oe,
  input wire logic       o_port3_carrier_sense_oe,
  input wire logic       o_port3_collision,
  input wire logic       o_port3_rx_valid,
  input wire logic [3:0] o_port3_rx_nibble,
  input wire logic       o_port3_carrier_sense,
  input wire link_mode_t o_mode,
  input wire logic       o_mode_valid
);
  logic oe_any, oe_gen, fw, rv, sr;
  // per-mode summaries of pin drive
  assign oe_gen = o_port3_tx_clock_oe & o_port3_rx_clock_oe & o_port3_collision_oe;
  assign oe_any = o_port3_tx_clock_oe | o_port3_rx_clock_oe | o_port3_collision_oe
                | o_port3_carrier_sense_oe;
  assign fw = o_mode_valid && o_mode == MODE_FWD;
  assign rv = o_mode_valid && o_mode == MODE_REV;
  assign sr = o_mode_valid && o_mode == MODE_SERIAL;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  property p_fwd_quiet;
    fw |-> !oe_any && !o_port3_collision;
  endproperty
  a_fwd_quiet: assert property (p_fwd_quiet) else $error("forward pin driven");
  // pin enables are registered, so they trail the captured mode by one cycle
  property p_rev_pins;
    rv && $past(rv) |-> oe_gen && o_port3_carrier_sense_oe;
  endproperty
  a_rev_pins: assert property (p_rev_pins) else $error("reverse pin undriven");
  property p_ser_pins;
    sr && $past(sr) |-> oe_gen && !o_port3_carrier_sense_oe && o_port3_rx_nibble[3:1] == 3'h0;
  endproperty
  a_ser_pins: assert property (p_ser_pins) else $error("serial pin set wrong");
  property p_quiet_pre;
    !o_mode_valid |-> !oe_any && !o_port3_rx_valid;
  endproperty
  a_quiet_pre: assert property (p_quiet_pre) else $error("link active before mode");
  property p_mode_held;
    o_mode_valid |=> o_mode_valid && $stable(o_mode);
  endproperty
  a_mode_held: assert property (p_mode_held) else $error("mode changed");
  property p_coll_half;
    $rose(o_port3_collision) |-> $past(i_half_duplex);
  endproperty
  a_coll_half: assert property (p_coll_half) else $error("collision in full duplex");
  property p_in_hold;
    o_in_valid && !i_in_ready |=> o_in_valid && $stable(o_in_data) && $stable(o_in_last);
  endproperty
  a_in_hold: assert property (p_in_hold) else $error("stalled byte moved");
  property p_eg_take;
    i_eg_valid && o_eg_ready |=> !o_eg_ready;
  endproperty
  a_eg_take: assert property (p_eg_take) else $error("hold not filled");
  property p_rev_crs;
    rv && $rose(o_port3_rx_valid) |-> ##[0:3] o_port3_carrier_sense;
  endproperty
  a_rev_crs: assert property (p_rev_crs) else $error("no carrier on send");
endmodule

// File: verif/p3_link_peer.sv
// far end of the link: external mac, phy or serial controller
// assumes i_lclk is the link clock both ends use
`timescale 1ns/1ps
module p3_link_peer (
  input  wire logic       i_lclk,
  input  wire logic       i_serial,
  input  wire logic       i_rx_valid,
  input  wire logic [3:0] i_rx_nibble,
  output logic            o_en,
  output logic [3:0]      o_data
);
  typedef logic [7:0] oct_t;
  logic [8:0] rx_q[$];
  logic [7:0] acc;
  int         cnt;
  bit         busy;
  int         drop;

  // idle; no error line exists here, the bench drives that pin with junk
  initial
  begin
    o_en = 1'b0;
    o_data = 4'h0;
    cnt = 0;
    busy = 0;
    drop = 0;
  end

  // enable qualifies units, low unit first
  task automatic send(input oct_t f[$]);
    int u;
    busy = 1;
    foreach (f[i])
      // drop cuts units off the final byte to make a fragment
      for (u = 0; u < (i_serial ? 8 : 2) - ((i == f.size() - 1) ? drop : 0); u++)
      begin
        @(negedge i_lclk);
        o_en <= 1'b1;
        o_data <= i_serial ? {~o_data[3:1], f[i][u]} : f[i][u*4 +: 4];
      end
    @(negedge i_lclk);
    o_en <= 1'b0;
    o_data <= ~o_data; // released data must not mimic held data
    busy = 0;
  endtask

  // gather units while valid is shown
  always @(posedge i_lclk)
  begin
    if (i_rx_valid === 1'b1 && !busy)
    begin
      acc = i_serial ? {i_rx_nibble[0], acc[7:1]} : {i_rx_nibble, acc[7:4]};
      cnt = cnt + (i_serial ? 1 : 4);
      if (cnt == 8)
      begin
        rx_q.push_back({1'b0, acc});
        cnt = 0;
      end
    end
    else
      cnt = 0;
  end
endmodule

// File: verif/tb_p3_link.sv
// top bench for the third-port link against the far-end model
// assumes p3_link, p3_link_peer and p3_link_sva are compiled first
`timescale 1ns/1ps
module tb_p3_link;
  import p3_link_pkg::*;
  localparam int DEPTH = 2;
  typedef logic [7:0] frame_t[$];
  logic       i_clk, i_arst_n, i_speed_100, i_half_duplex, i_port3_tx_error, i_in_ready;
  logic [1:0] i_mode_strap;
  logic       i_port3_tx_enable, i_port3_collision_in, i_port3_carrier_sense;
  logic [3:0] i_port3_tx_nibble, o_port3_rx_nibble;
  logic [7:0] i_eg_data, o_in_data;
  logic       i_eg_valid, i_eg_last, i_port3_tx_clock, i_port3_rx_clock;
  logic       o_port3_tx_clock, o_port3_tx_clock_oe, o_port3_rx_clock, o_port3_rx_clock_oe;
  logic       o_port3_rx_valid, o_port3_collision, o_port3_collision_oe, o_eg_ready;
  logic       o_port3_carrier_sense, o_port3_carrier_sense_oe, o_eg_underrun, o_in_valid;
  logic       o_in_last, o_in_overrun, o_in_fragment, o_collision, o_carrier_sense;
  logic       o_mode_valid, fclk, frun, fwd, ser, lclk, stall, col, ovr, unr, frg;
  link_mode_t o_mode;
  logic [8:0] in_q[$];
  logic [31:0] seed = 32'h9ffbf56d;
  int         err_total, check_count;

  assign i_port3_tx_clock = fclk;
  assign i_port3_rx_clock = fclk;
  assign lclk = fwd ? fclk : o_port3_tx_clock;

  p3_link #(.BUF_DEPTH(DEPTH)) dut_u (
    .i_clk, .i_arst_n, .i_mode_strap, .i_speed_100, .i_half_duplex, .i_port3_tx_enable,
    .i_port3_tx_nibble, .i_port3_tx_error, .i_port3_tx_clock, .o_port3_tx_clock,
    .o_port3_tx_clock_oe, .i_port3_rx_clock, .o_port3_rx_clock, .o_port3_rx_clock_oe,
    .o_port3_rx_valid, .o_port3_rx_nibble, .o_port3_collision, .o_port3_collision_oe,
    .i_port3_collision_in, .i_port3_carrier_sense, .o_port3_carrier_sense,
    .o_port3_carrier_sense_oe, .i_eg_valid, .i_eg_data, .i_eg_last, .o_eg_ready,
    .o_eg_underrun, .o_in_valid, .o_in_data, .o_in_last, .i_in_ready, .o_in_overrun,
    .o_in_fragment, .o_collision, .o_carrier_sense, .o_mode, .o_mode_valid
  );

  p3_link_peer peer_u (
    .i_lclk(lclk), .i_serial(ser), .i_rx_valid(o_port3_rx_valid),
    .i_rx_nibble(o_port3_rx_nibble), .o_en(i_port3_tx_enable), .o_data(i_port3_tx_nibble)
  );

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic frame_t mk(input int n);
    frame_t f;
    repeat (n) f.push_back(8'(xs()));
    return f;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // byte model: last flag only on the final byte of a frame
  task automatic cmp(input logic [8:0] got[$], input frame_t f, input bit lst);
    chk("count", got.size(), f.size());
    foreach (f[i])
      if (i < got.size())
        chk("byte", got[i], {lst && i == f.size() - 1, f[i]});
  endtask

  task automatic test_done;
    if (err_total == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic boot(input logic [1:0] s, input logic sp, input logic fw);
    i_arst_n = 1'b0;
    i_mode_strap = s;
    i_speed_100 = sp;
    frun = fw;
    fwd = fw;
    repeat (8) @(posedge i_clk);
    #1 i_arst_n = 1'b1;
    repeat (20) if (o_mode_valid !== 1'b1) @(posedge i_clk) #1;
    // pin enables settle one cycle after the mode is caught
    @(posedge i_clk) #1;
  endtask

  // source holds each byte until the edge that sees ready
  task automatic eg_send(input frame_t f);
    foreach (f[i])
    begin
      i_eg_valid = 1'b1;
      i_eg_data = f[i];
      i_eg_last = (i == f.size() - 1);
      while (o_eg_ready !== 1'b1) @(posedge i_clk) #1;
      @(posedge i_clk) #1;
    end
    i_eg_valid = 1'b0;
  endtask

  task automatic run(input logic [1:0] s, input logic sp, input link_mode_t m);
    frame_t f;
    realtime t0;
    boot(s, sp, m == MODE_FWD);
    ser = (m == MODE_SERIAL);
    chk("mode", o_mode, m);
    chk("clock_oe", o_port3_tx_clock_oe, m != MODE_FWD);
    if (m == MODE_REV && !sp)
    begin
      @(posedge o_port3_tx_clock) t0 = $realtime;
      @(posedge o_port3_tx_clock) chk("period", int'($realtime - t0), 400);
      @(posedge o_port3_rx_clock) t0 = $realtime;
      @(posedge o_port3_rx_clock) chk("rx_period", int'($realtime - t0), 400);
      @(posedge i_clk) #1;
    end
    f = mk(5);
    peer_u.rx_q.delete();
    unr = 0;
    eg_send(f);
    repeat (3000) if (peer_u.rx_q.size() < 5) @(posedge i_clk) #1;
    cmp(peer_u.rx_q, f, 0);
    chk("underrun", unr, 0);
    f = mk(5);
    in_q.delete();
    frg = 1'b0;
    peer_u.send(f);
    repeat (3000) if (in_q.size() < 5) @(posedge i_clk) #1;
    cmp(in_q, f, 1);
    chk("fragment", frg, 0);
  endtask

  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // phy link clock at 320 ns, still unless a forward test runs
  initial
  begin
    fclk = 1'b0;
    forever #160 if (frun) fclk = ~fclk;
  end

  // random core stalls and junk on the ignored error input
  always @(posedge i_clk)
  begin
    i_in_ready <= #1 !stall && xs() % 4 != 0;
    i_port3_tx_error <= #1 (xs() & 32'h1) != 0;
  end

  // core sink and event flags
  always @(posedge i_clk)
  begin
    if (o_in_valid === 1'b1 && i_in_ready === 1'b1)
      in_q.push_back({o_in_last, o_in_data});
    if (o_in_overrun === 1'b1)
      ovr = 1'b1;
    if (o_port3_collision === 1'b1)
      col = 1'b1;
    if (o_eg_underrun === 1'b1)
      unr = 1'b1;
    if (o_in_fragment === 1'b1)
      frg = 1'b1;
  end

  initial
  begin
    frame_t f;
    int h;
    {i_arst_n, i_speed_100, i_half_duplex, i_port3_collision_in} = 4'h0;
    {i_port3_carrier_sense, i_eg_valid, i_eg_last, i_in_ready, i_port3_tx_error} = 5'h00;
    {frun, fwd, ser, stall, col, ovr, unr, frg} = 8'h00;
    i_mode_strap = 2'h0;
    i_eg_data = 8'h00;
    run(2'h1, 1'b0, MODE_REV);
    run(2'h1, 1'b1, MODE_REV);
    run(2'h2, 1'b0, MODE_SERIAL);
    run(2'h0, 1'b1, MODE_FWD);
    {i_port3_collision_in, i_port3_carrier_sense} = 2'h3;
    repeat (6) @(posedge i_clk) #1;
    chk("coll_in", o_collision, 1);
    chk("crs_in", o_carrier_sense, 1);
    {i_port3_collision_in, i_port3_carrier_sense} = 2'h0;
    // core stalled: buffer fills, later bytes dropped
    boot(2'h1, 1'b1, 1'b0);
    f = mk(5);
    {stall, ovr} = 2'h2;
    in_q.delete();
    peer_u.send(f);
    repeat (20) @(posedge i_clk) #1;
    stall = 0;
    repeat (40) @(posedge i_clk) #1;
    chk("overrun", ovr, 1);
    f = f[0:DEPTH-1];
    cmp(in_q, f, 0);
    // cut frame: half byte at the end is dropped, byte before it marked last
    peer_u.drop = 1;
    f = mk(3);
    in_q.delete();
    frg = 1'b0;
    peer_u.send(f);
    peer_u.drop = 0;
    repeat (40) @(posedge i_clk) #1;
    chk("fragment", frg, 1);
    f = f[0:1];
    cmp(in_q, f, 1);
    for (h = 0; h < 2; h++)
    begin
      boot(2'h1, 1'b0, 1'b0);
      i_half_duplex = h[0];
      col = 0;
      fork
        eg_send(f);
        peer_u.send(f);
      join
      chk("collision", col, h);
    end
    test_done;
  end

  // hang guard, far beyond the expected run
  initial
  begin
    #2000000;
    err_total++;
    test_done;
  end
endmodule

bind p3_link p3_link_sva chk_u (
  .i_clk, .i_arst_n, .i_half_duplex, .i_eg_valid, .o_eg_ready, .i_in_ready, .o_in_valid,
  .o_in_data, .o_in_last, .o_port3_tx_clock_oe, .o_port3_rx_clock_oe, .o_port3_collision_oe,
  .o_port3_carrier_sense_oe, .o_port3_collision, .o_port3_rx_valid, .o_port3_rx_nibble,
  .o_port3_carrier_sense, .o_mode, .o_mode_valid
);
